// [design/ckpd_top.sv]
// Clock and power-down controller: register file, medium-speed divider, bus-master clock
// enable, sleep and standby sequencing, module halt and reset outputs.
// Assumes the CPU pulses sleep_exec_i on the sleep instruction and wake pulses come from
// the interrupt controller; clocks to gated domains are derived from the enables driven here.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Feedback-bypass bit set disconnects feedback resistor and duty adjust circuit.
// - Low five reserved bits of low-power control store but do nothing.
// - Duty adjust applies only when oscillator runs at 5 MHz or more.
// - Divider produces system clock over 2, 4, 8, 16 and 32.
// - Bus masters get full clock or one divided clock chosen by select field.
// - Select codes 000 full, 001..101 divide 2..32, 11x unassigned.
// - Reset brings full speed, no division, no sleep, no standby.
// - Sleep, medium speed and module halt may all be active together.
// - Medium speed slows bus masters only; peripherals and ports stay full speed.
// - Halt or standby resets serial units and converter; others keep state.
// - Oscillator-halting modes stop both CPU and oscillator.
// - Standby control holds deep-standby bit7, wake-wait 6:4, bus hold bit3.
// - Standby control resets to 08h and survives software standby.
// - Deep-standby bit stays set after wakeup; only a software write, reset or hardware standby clears it.
// - Sleep instruction with deep-standby clear enters sleep mode.
// - Sleep instruction with deep-standby set enters software standby.
// - Wake-wait codes give 8192..262144 states, 111 gives 16, 110 reserved.
// - Bus hold clear floats address and control during software standby, set holds; hardware standby always floats.
// - Registers decode at FF38, FF3A, FF3C, FF3D and FF44.
// - Module halt low resets to FFh and high to 3Fh.
module ckpd_top
    import ckpd_pkg::*;
#(
    parameter int OSC_KHZ = 20000
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic hw_standby_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sleep_exec_i,
    input wire logic irq_wake_i,
    input wire logic ext_irq_wake_i,
    output logic [7:0] rdata_o,
    output logic bm_clk_en_o,
    output logic cpu_run_o,
    output logic osc_run_o,
    output logic feedback_on_o,
    output logic duty_adjust_on_o,
    output logic clk_out_en_o,
    output logic bus_float_o,
    output logic [15:0] module_halt_o,
    output logic [15:0] module_reset_o,
    output logic sleeping_o,
    output logic standby_o
);
    logic [7:0] standby_control;
    logic [7:0] system_clock_control;
    logic [7:0] module_halt_high;
    logic [7:0] module_halt_low;
    logic [7:0] low_power_control;
    logic [DIV_WIDTH-1:0] div_cnt;
    logic [18:0] wait_cnt;
    logic [18:0] wait_len;
    logic [DIV_WIDTH-1:0] div_mask;
    logic next_bm_en;
    logic [2:0] div_sel;
    logic [15:0] halt_vec;
    logic lp_reset;
    ckpd_state_e state;
    ckpd_state_e next_state;

    // Hardware standby behaves as a reset of every control register
    assign lp_reset = hw_standby_i;
    assign div_sel = system_clock_control[DIV_SEL_MSB:0];
    assign halt_vec = {module_halt_high, module_halt_low};

    // Register writes; strobes act at the end of their one bus cycle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            standby_control <= RST_STANDBY_CONTROL;
            system_clock_control <= RST_SYSTEM_CLOCK_CONTROL;
            module_halt_high <= RST_MODULE_HALT_HIGH;
            module_halt_low <= RST_MODULE_HALT_LOW;
            low_power_control <= RST_LOW_POWER_CONTROL;
        end else if (clk_en_i) begin
            if (lp_reset) begin
                standby_control <= RST_STANDBY_CONTROL;
                system_clock_control <= RST_SYSTEM_CLOCK_CONTROL;
                module_halt_high <= RST_MODULE_HALT_HIGH;
                module_halt_low <= RST_MODULE_HALT_LOW;
                low_power_control <= RST_LOW_POWER_CONTROL;
            end else if (wr_i) begin
                // Deep-standby bit is changed here or by reset and hardware standby, never by wakeup
                unique case (addr_i)
                    ADDR_STANDBY_CONTROL:
                        standby_control <= wdata_i & MASK_STANDBY_CONTROL;
                    ADDR_SYSTEM_CLOCK_CONTROL:
                        system_clock_control <= wdata_i & MASK_SYSTEM_CLOCK_CONTROL;
                    ADDR_MODULE_HALT_HIGH: module_halt_high <= wdata_i;
                    ADDR_MODULE_HALT_LOW: module_halt_low <= wdata_i;
                    ADDR_LOW_POWER_CONTROL: low_power_control <= wdata_i;
                    default: ;
                endcase
            end
        end
    end

    // Read data, valid the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (rd_i) begin
                unique case (addr_i)
                    ADDR_STANDBY_CONTROL: rdata_o <= standby_control;
                    ADDR_SYSTEM_CLOCK_CONTROL: rdata_o <= system_clock_control;
                    ADDR_MODULE_HALT_HIGH: rdata_o <= module_halt_high;
                    ADDR_MODULE_HALT_LOW: rdata_o <= module_halt_low;
                    ADDR_LOW_POWER_CONTROL: rdata_o <= low_power_control;
                    default: rdata_o <= 8'h00;
                endcase
            end else begin
                rdata_o <= 8'h00;
            end
        end
    end

    // Free-running medium-speed divider; bit k toggles at system clock over 2^(k+1)
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt <= '0;
        end else if (clk_en_i) begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // Mask of low counter bits that must all be one for a divided-clock pulse
    always_comb begin
        unique case (div_sel)
            3'h0: div_mask = 5'h00;
            3'h1: div_mask = 5'h01;
            3'h2: div_mask = 5'h03;
            3'h3: div_mask = 5'h07;
            3'h4: div_mask = 5'h0F;
            3'h5: div_mask = 5'h1F;
            // Unassigned codes fall back to full speed rather than stall the CPU
            default: div_mask = 5'h00;
        endcase
    end

    // Bus masters get one enable per divided period; others stay on full clock
    assign next_bm_en = ((div_cnt & div_mask) == div_mask);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bm_clk_en_o <= 1'b1;
        end else if (clk_en_i) begin
            bm_clk_en_o <= next_bm_en && (state == CKPD_RUN || state == CKPD_SLEEP);
        end
    end

    // Wake-wait length from the select field
    always_comb begin
        unique case (standby_control[WAKE_WAIT_MSB:WAKE_WAIT_LSB])
            3'h0: wait_len = WAIT_0;
            3'h1: wait_len = WAIT_1;
            3'h2: wait_len = WAIT_2;
            3'h3: wait_len = WAIT_3;
            3'h4: wait_len = WAIT_4;
            3'h5: wait_len = WAIT_5;
            3'h7: wait_len = WAIT_7;
            // Reserved code: use the longest wait, the safe side for a crystal
            default: wait_len = WAIT_5;
        endcase
    end

    // Power state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            CKPD_RUN: begin
                if (sleep_exec_i) begin
                    if (standby_control[DEEP_STANDBY_BIT]) begin
                        next_state = CKPD_STANDBY;
                    end else begin
                        next_state = CKPD_SLEEP;
                    end
                end
            end
            CKPD_SLEEP: begin
                if (irq_wake_i || ext_irq_wake_i) begin
                    next_state = CKPD_RUN;
                end
            end
            CKPD_STANDBY: begin
                if (ext_irq_wake_i) begin
                    next_state = CKPD_WAKE;
                end
            end
            CKPD_WAKE: begin
                if (wait_cnt == 19'h00001) begin
                    next_state = CKPD_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= CKPD_RUN;
        end else if (clk_en_i) begin
            state <= lp_reset ? CKPD_RUN : next_state;
        end
    end

    // Settling counter: loaded on wake, counts states until the clock is trusted
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_cnt <= '0;
        end else if (clk_en_i) begin
            if (state == CKPD_STANDBY && ext_irq_wake_i) begin
                wait_cnt <= wait_len;
            end else if (state == CKPD_WAKE && wait_cnt != 19'h00000) begin
                wait_cnt <= wait_cnt - 19'h00001;
            end
        end
    end

    // Mode outputs, all registered from next state so they align with it
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_run_o <= 1'b1;
            osc_run_o <= 1'b1;
            sleeping_o <= 1'b0;
            standby_o <= 1'b0;
            bus_float_o <= 1'b0;
            clk_out_en_o <= 1'b1;
        end else if (clk_en_i) begin
            cpu_run_o <= (next_state == CKPD_RUN) && !lp_reset;
            osc_run_o <= (next_state != CKPD_STANDBY) && !lp_reset;
            sleeping_o <= (next_state == CKPD_SLEEP) && !lp_reset;
            standby_o <= (next_state == CKPD_STANDBY || next_state == CKPD_WAKE) && !lp_reset;
            // Float during hardware standby, or while in software standby with hold clear
            bus_float_o <= lp_reset || ((next_state == CKPD_STANDBY || next_state == CKPD_WAKE)
                && !standby_control[BUS_HOLD_BIT]);
            clk_out_en_o <= !system_clock_control[CLK_OUT_OFF_BIT] && !lp_reset
                && (next_state == CKPD_RUN || next_state == CKPD_SLEEP);
        end
    end

    // Module halt and reset lines; halt follows its registers in run and sleep, standby halts every module
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            module_halt_o <= {RST_MODULE_HALT_HIGH, RST_MODULE_HALT_LOW};
            module_reset_o <= RESET_ON_HALT_MASK;
        end else if (clk_en_i) begin
            if (next_state == CKPD_STANDBY || next_state == CKPD_WAKE) begin
                module_halt_o <= 16'hFFFF;
                module_reset_o <= RESET_ON_HALT_MASK;
            end else begin
                module_halt_o <= halt_vec;
                module_reset_o <= halt_vec & RESET_ON_HALT_MASK;
            end
        end
    end

    // Oscillator options; duty adjust only meaningful at 5 MHz and up
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            feedback_on_o <= 1'b1;
            duty_adjust_on_o <= 1'b0;
        end else if (clk_en_i) begin
            feedback_on_o <= !low_power_control[FEEDBACK_BYPASS_BIT];
            duty_adjust_on_o <= !low_power_control[FEEDBACK_BYPASS_BIT]
                && (OSC_KHZ >= DUTY_MIN_KHZ);
        end
    end

    // Checks
    sequence s_sleep_cmd;
        sleep_exec_i && clk_en_i && state == CKPD_RUN && !lp_reset;
    endsequence

    chk_sleep_entry: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (s_sleep_cmd and !standby_control[DEEP_STANDBY_BIT]) |=> sleeping_o && !cpu_run_o)
        else $error("sleep not entered");

    chk_standby_entry: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (s_sleep_cmd and standby_control[DEEP_STANDBY_BIT]) |=> standby_o && !osc_run_o)
        else $error("standby not entered");

    chk_osc_cpu_stop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !osc_run_o |-> !cpu_run_o)
        else $error("cpu runs without oscillator");

    chk_deep_sticky: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i && !wr_i && !lp_reset && standby_control[DEEP_STANDBY_BIT]
        |=> standby_control[DEEP_STANDBY_BIT])
        else $error("deep standby bit lost");

    chk_feedback_cut: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i && low_power_control[FEEDBACK_BYPASS_BIT]
        |=> !feedback_on_o && !duty_adjust_on_o)
        else $error("feedback not bypassed");

    chk_bus_float: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        standby_o && !$past(standby_control[BUS_HOLD_BIT]) && !lp_reset |-> bus_float_o)
        else $error("bus not floated");

    chk_halt_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        module_reset_o == (module_halt_o & RESET_ON_HALT_MASK))
        else $error("serial or converter reset wrong");

    chk_full_speed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i && div_sel == DIV_FULL && state == CKPD_RUN ##1 clk_en_i
        && $stable(state) |-> bm_clk_en_o)
        else $error("full speed enable missing");

    chk_reg_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i && wr_i && !lp_reset && addr_i == ADDR_MODULE_HALT_LOW
        |=> module_halt_low == $past(wdata_i))
        else $error("module halt low write lost");
endmodule : ckpd_top
`default_nettype wire

// [shared/ckpd_pkg.sv]
// Package for the clock and power-down controller: register map, fields, reset values, timing.
// Assumes a 16-bit low register address and 8-bit data on a plain strobe port.
package ckpd_pkg;
    // Register addresses (low 16 bits)
    localparam logic [15:0] ADDR_STANDBY_CONTROL = 16'hFF38;
    localparam logic [15:0] ADDR_SYSTEM_CLOCK_CONTROL = 16'hFF3A;
    localparam logic [15:0] ADDR_MODULE_HALT_HIGH = 16'hFF3C;
    localparam logic [15:0] ADDR_MODULE_HALT_LOW = 16'hFF3D;
    localparam logic [15:0] ADDR_LOW_POWER_CONTROL = 16'hFF44;
    // Reset values
    localparam logic [7:0] RST_STANDBY_CONTROL = 8'h08;
    localparam logic [7:0] RST_SYSTEM_CLOCK_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODULE_HALT_HIGH = 8'h3F;
    localparam logic [7:0] RST_MODULE_HALT_LOW = 8'hFF;
    localparam logic [7:0] RST_LOW_POWER_CONTROL = 8'h00;
    // Field positions
    localparam int DEEP_STANDBY_BIT = 7;
    localparam int WAKE_WAIT_MSB = 6;
    localparam int WAKE_WAIT_LSB = 4;
    localparam int BUS_HOLD_BIT = 3;
    localparam int CLK_OUT_OFF_BIT = 7;
    localparam int CLK_RSV_BIT = 6;
    localparam int DIV_SEL_MSB = 2;
    localparam int FEEDBACK_BYPASS_BIT = 5;
    // Writable masks (read-only bits read zero)
    localparam logic [7:0] MASK_STANDBY_CONTROL = 8'hF8;
    localparam logic [7:0] MASK_SYSTEM_CLOCK_CONTROL = 8'hC7;
    // Module halt bits that reset their module when stopped
    localparam logic [15:0] RESET_ON_HALT_MASK = 16'h02E0;
    // Divider codes
    localparam logic [2:0] DIV_FULL = 3'h0;
    localparam logic [2:0] DIV_MAX = 3'h5;
    localparam int DIV_WIDTH = 5;
    // Duty adjust threshold
    localparam int DUTY_MIN_KHZ = 5000;
    // Wake-wait state counts
    localparam logic [18:0] WAIT_0 = 19'h02000;
    localparam logic [18:0] WAIT_1 = 19'h04000;
    localparam logic [18:0] WAIT_2 = 19'h08000;
    localparam logic [18:0] WAIT_3 = 19'h10000;
    localparam logic [18:0] WAIT_4 = 19'h20000;
    localparam logic [18:0] WAIT_5 = 19'h40000;
    localparam logic [18:0] WAIT_7 = 19'h00010;
    // Power states
    typedef enum logic [1:0] {
        CKPD_RUN = 2'b00,
        CKPD_SLEEP = 2'b01,
        CKPD_STANDBY = 2'b10,
        CKPD_WAKE = 2'b11
    } ckpd_state_e;
endpackage : ckpd_pkg

// [sim/ckpd_cpu_model.sv]
// Behavioural model of the on-chip CPU side: register bus master plus sleep and wake strobes.
// Assumes the testbench calls its tasks one at a time; all signals move right after mclk_i rises.
`timescale 1ns/100ps
`default_nettype none
module ckpd_cpu_model (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic sleep_o,
    output logic irq_o,
    output logic ext_irq_o
);
    // Idle bus at time zero; the clock source is never swapped, so no swap outside standby
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        sleep_o = 1'b0;
        irq_o = 1'b0;
        ext_irq_o = 1'b0;
    end

    // Single-cycle write, data dropped to its inverse once released
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // Single-cycle read; data taken in the one cycle where it stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd

    // One-cycle pulse: 0 sleep instruction, 1 any interrupt, 2 external interrupt
    task automatic pulse(input logic [1:0] sel);
        @(posedge mclk_i);
        case (sel)
            2'h0: sleep_o <= 1'b1;
            2'h1: irq_o <= 1'b1;
            default: ext_irq_o <= 1'b1;
        endcase
        @(posedge mclk_i);
        sleep_o <= 1'b0;
        irq_o <= 1'b0;
        ext_irq_o <= 1'b0;
        // Return once the answering edge has settled, so callers see its outputs
        #1;
    endtask : pulse
endmodule : ckpd_cpu_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the clock and power-down controller.
// Assumes a 20 MHz system clock; the CPU model drives the register bus and sleep strobes.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ckpd_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic hw_standby_i = 1'b0;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, d;
    logic wr, rd, slp, irq, ext, bm_en, cpu_run, osc_run, fb_on, duty_on, float, sleeping, standby;
    logic [15:0] halt, mreset;
    logic clk_out;
    logic [31:0] seed = 32'h2CDC;
    int error_cnt = 0;
    int comparisons = 0;
    int cnt;

    // Clock at 50 ns period
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end

    ckpd_cpu_model cpu_u (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .sleep_o(slp), .irq_o(irq), .ext_irq_o(ext));

    ckpd_top dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
        .hw_standby_i(hw_standby_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .sleep_exec_i(slp), .irq_wake_i(irq), .ext_irq_wake_i(ext), .rdata_o(rdata),
        .bm_clk_en_o(bm_en), .cpu_run_o(cpu_run), .osc_run_o(osc_run), .feedback_on_o(fb_on),
        .duty_adjust_on_o(duty_on), .clk_out_en_o(clk_out), .bus_float_o(float),
        .module_halt_o(halt), .module_reset_o(mreset), .sleeping_o(sleeping),
        .standby_o(standby));

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    // Enables per 64 cycles for a divider code; unassigned codes run at full speed
    function automatic int bm_per_64(input logic [2:0] code);
        return (code >= 3'h1 && code <= DIV_MAX) ? (64 >> code) : 64;
    endfunction : bm_per_64

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cpu_u.rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Watchdog sized well beyond the under a thousand cycles the sequence needs
    initial begin
        #(50 * 20000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        logic [7:0] v;
        logic [2:0] c;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        // Reset state and register reset values, plus an unmapped hole
        rd_chk(ADDR_STANDBY_CONTROL, 8'h08);
        rd_chk(ADDR_SYSTEM_CLOCK_CONTROL, 8'h00);
        rd_chk(ADDR_MODULE_HALT_HIGH, 8'h3F);
        rd_chk(ADDR_MODULE_HALT_LOW, 8'hFF);
        rd_chk(16'hFF39, 8'h00);
        chk({bm_en, cpu_run, sleeping, standby, clk_out, halt}, {5'h19, 16'h3FFF});
        // Random register contents with write masks; unmapped writes vanish
        repeat (6) begin
            v = 8'(xorshift());
            cpu_u.wr(16'hFF3B, v);
            cpu_u.wr(ADDR_STANDBY_CONTROL, v);
            rd_chk(ADDR_STANDBY_CONTROL, v & 8'hF8);
            cpu_u.wr(ADDR_MODULE_HALT_HIGH, ~v);
            cpu_u.wr(ADDR_MODULE_HALT_LOW, v);
            @(posedge mclk_i);
            #1;
            chk(halt, {~v, v});
            chk(mreset, {~v, v} & 16'h02E0);
        end
        // Feedback bypass against reserved low bits
        cpu_u.wr(ADDR_LOW_POWER_CONTROL, 8'hDF);
        rd_chk(ADDR_LOW_POWER_CONTROL, 8'hDF);
        chk({fb_on, duty_on}, 2'b11);
        cpu_u.wr(ADDR_LOW_POWER_CONTROL, 8'h20);
        @(posedge mclk_i);
        #1;
        chk({fb_on, duty_on}, 2'b00);
        cpu_u.wr(ADDR_LOW_POWER_CONTROL, 8'h00);
        // Every divider code, counting bus-master enables over 64 cycles
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            cpu_u.wr(ADDR_SYSTEM_CLOCK_CONTROL, {5'h00, c});
            repeat (3) @(posedge mclk_i);
            cnt = 0;
            repeat (64) begin
                @(posedge mclk_i);
                #1;
                cnt += int'(bm_en);
            end
            chk(cnt, bm_per_64(c));
        end
        // Clock output switched off by its control bit
        cpu_u.wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'h80);
        @(posedge mclk_i);
        #1;
        chk(clk_out, 1'b0);
        // Sleep while divided: CPU stops, divider and oscillator keep going
        cpu_u.wr(ADDR_SYSTEM_CLOCK_CONTROL, 8'h02);
        cpu_u.wr(ADDR_STANDBY_CONTROL, 8'h70);
        cpu_u.pulse(2'h0);
        chk({sleeping, cpu_run, osc_run, standby}, 4'hA);
        cpu_u.pulse(2'h1);
        @(posedge mclk_i);
        #1;
        chk({sleeping, cpu_run}, 2'b01);
        rd_chk(ADDR_SYSTEM_CLOCK_CONTROL, 8'h02);
        // Software standby with the 16-state wake wait and floating bus
        cpu_u.wr(ADDR_STANDBY_CONTROL, 8'hF0);
        cpu_u.pulse(2'h0);
        chk({standby, osc_run, cpu_run, float, clk_out}, 5'h12);
        chk({halt, mreset}, {16'hFFFF, 16'h02E0});
        cpu_u.pulse(2'h1);
        chk({standby, osc_run}, 2'b10);
        cpu_u.pulse(2'h2);
        chk({standby, osc_run}, 2'b11);
        cnt = 0;
        while (standby === 1'b1 && cnt < 40) begin
            @(posedge mclk_i);
            #1;
            cnt++;
        end
        chk(cnt, WAIT_7);
        chk({cpu_run, float}, 2'b10);
        rd_chk(ADDR_STANDBY_CONTROL, 8'hF0);
        // Hardware standby reloads the register defaults
        @(posedge mclk_i);
        hw_standby_i <= 1'b1;
        @(posedge mclk_i);
        hw_standby_i <= 1'b0;
        rd_chk(ADDR_STANDBY_CONTROL, 8'h08);
        rd_chk(ADDR_MODULE_HALT_HIGH, 8'h3F);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
